// File: verilog/dasc_defs.svh
// Register offsets, field positions and timing constants of the dual serial channel
`ifndef DASC_DEFS_SVH
`define DASC_DEFS_SVH

// Register index inside one channel; reg_addr[3] selects the channel
`define DASC_REG_CTRL 3'h0
`define DASC_REG_BAUD 3'h1
`define DASC_REG_TXBUF 3'h2
`define DASC_REG_RXBUF 3'h3
`define DASC_REG_STAT 3'h4
`define DASC_REG_MASK 3'h5

// Control register bits
`define DASC_CTRL_EN 0
`define DASC_CTRL_SYNC 1
`define DASC_CTRL_NINE 2
`define DASC_CTRL_TWO_STOP 3
`define DASC_CTRL_PAR_EN 4
`define DASC_CTRL_PAR_ODD 5
`define DASC_CTRL_WAKE 6
`define DASC_CTRL_LOOP 7
`define DASC_CTRL_FE_EN 8
`define DASC_CTRL_OE_EN 9
`define DASC_CTRL_REN 10
`define DASC_CTRL_RESET 16'h0000
`define DASC_CTRL_REN_MASK 16'h0400

// Status bits; 0..5 sticky, write one to clear; 6..7 live state
`define DASC_ST_TX 0
`define DASC_ST_RX 1
`define DASC_ST_ERR 2
`define DASC_ST_PE 3
`define DASC_ST_FE 4
`define DASC_ST_OE 5
`define DASC_ST_TX_BUSY 6
`define DASC_ST_RX_FULL 7

`define DASC_BAUD_RESET 16'h0000
`define DASC_MASK_RESET 3'h0

// Rates
`define DASC_CLK_KHZ 100000
`define DASC_ASYNC_MAX_KBAUD 625
`define DASC_SYNC_MAX_KBAUD 2500
`define DASC_OVERSAMPLE 16
`define DASC_ASYNC_MIN_DIV ((`DASC_CLK_KHZ + `DASC_OVERSAMPLE * `DASC_ASYNC_MAX_KBAUD - 1) / (`DASC_OVERSAMPLE * `DASC_ASYNC_MAX_KBAUD))
`define DASC_SYNC_MIN_DIV ((`DASC_CLK_KHZ + 2 * `DASC_SYNC_MAX_KBAUD - 1) / (2 * `DASC_SYNC_MAX_KBAUD))
`define DASC_ASYNC_MIN_RELOAD 16'(`DASC_ASYNC_MIN_DIV - 1)
`define DASC_SYNC_MIN_RELOAD 16'(`DASC_SYNC_MIN_DIV - 1)

// Sampling phases inside one 16-tick bit
`define DASC_PH_MID 4'h7
`define DASC_PH_LAST 4'hF

`endif

// File: verilog/dasc_pkg.sv
// Types and helpers of the dual serial channel
`default_nettype none
package dasc_pkg;

    typedef enum logic [1:0] {
        DASC_TX_IDLE = 2'b01,
        DASC_TX_RUN = 2'b10
    } dasc_tx_state_t;

    typedef enum logic [2:0] {
        DASC_RX_IDLE = 3'b001,
        DASC_RX_START = 3'b010,
        DASC_RX_DATA = 3'b100
    } dasc_rx_state_t;

    function automatic logic [15:0] dasc_floor(input logic [15:0] value, input logic [15:0] least);
        dasc_floor = (value < least) ? least : value;
    endfunction

endpackage
`default_nettype wire

// File: verilog/dasc_baud.sv
// Baud rate generator: reloadable down counter giving one tick per period
`timescale 1ns/100ps
`default_nettype none
module dasc_baud (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [15:0] reload,
    // Tick, one cycle every reload+1 clocks
    output logic tick
);
    logic [15:0] cnt;

    assign tick = run && (cnt == 16'h0000);

    // Held at reload while stopped so the first period after enable is whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 16'h0000;
        end else if (!run || tick) begin
            cnt <= reload;
        end else begin
            cnt <= cnt - 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: verilog/dasc_top.sv
// Two identical async/sync serial channels with register port and interrupts
// What this block does
// - Async mode full duplex up to 625 Kbaud
// - Sync mode one direction, up to 2.5 Mbaud
// - Own programmable baud generator per channel
// - Separate transmit, receive and error requests
// - Sync: device clocks exactly one byte
// - Frame: start, 8/9 data, 1/2 stops
// - Wake bit marks address versus data bytes
// - Loopback option receives own transmission
// - Parity generated on send, checked on receive
// - Missing stop bit flags framing error
// - Unread buffer on new character flags overrun
// - Two identical independently configured channels
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "dasc_defs.svh"
module dasc_top
    import dasc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Serial pins; index 0 is serial_channel_a, index 1 serial_channel_b
    output logic [1:0] txd,
    input wire logic [1:0] rxd_i,
    output logic [1:0] rxd_o,
    output logic [1:0] rxd_oe,
    // Interrupts
    output logic [1:0] irq_tx,
    output logic [1:0] irq_rx,
    output logic [1:0] irq_err,
    output logic irq
);
    logic rst_meta_n;
    logic rst_sync_n;
    logic [15:0] ch_rdata [2];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? ch_rdata[reg_addr[3]] : 16'h0000;
        end
    end

    assign irq = |{irq_tx, irq_rx, irq_err};

    for (genvar c = 0; c < 2; c++) begin : serial_channel
        logic [15:0] ctrl;
        logic [15:0] baud_rl;
        logic [5:0] stat;
        logic [2:0] mask;
        logic [8:0] rxbuf;
        logic rx_full;
        dasc_tx_state_t tx_state;
        logic [11:0] txsh;
        logic [3:0] tx_cnt;
        logic [3:0] tx_ph;
        logic sx_rx;
        logic [7:0] srxsh;
        logic txd_q;
        dasc_rx_state_t rx_state;
        logic [9:0] rxsh;
        logic [3:0] rx_cnt;
        logic [3:0] rx_ph;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic pin_lvl;
        logic line_q;

        wire sel = (reg_addr[3] == 1'(c));
        wire [2:0] idx = reg_addr[2:0];
        wire wr_ctrl = reg_wr && sel && (idx == `DASC_REG_CTRL);
        wire wr_baud = reg_wr && sel && (idx == `DASC_REG_BAUD);
        wire wr_tx = reg_wr && sel && (idx == `DASC_REG_TXBUF);
        wire wr_stat = reg_wr && sel && (idx == `DASC_REG_STAT);
        wire wr_mask = reg_wr && sel && (idx == `DASC_REG_MASK);
        wire rd_rx = reg_rd && sel && (idx == `DASC_REG_RXBUF);

        wire en = ctrl[`DASC_CTRL_EN];
        wire sync_m = ctrl[`DASC_CTRL_SYNC];
        wire wake = ctrl[`DASC_CTRL_WAKE];
        wire par_on = ctrl[`DASC_CTRL_PAR_EN] && !wake;
        wire par_odd = ctrl[`DASC_CTRL_PAR_ODD];
        // Parity and wake bit ride in the ninth bit, so both force 9-bit frames
        wire nine = ctrl[`DASC_CTRL_NINE] || wake || ctrl[`DASC_CTRL_PAR_EN];
        wire two_stop = ctrl[`DASC_CTRL_TWO_STOP];
        wire loop = ctrl[`DASC_CTRL_LOOP];

        // Reload is floored so software cannot exceed the rated bit rates
        wire [15:0] eff_rl = dasc_floor(baud_rl, sync_m ? `DASC_SYNC_MIN_RELOAD : `DASC_ASYNC_MIN_RELOAD);
        wire tick;
        wire baud_run;

        dasc_baud u_baud (
            .clk(ref_clk),
            .rst_n(rst_sync_n),
            .run(baud_run),
            .reload(eff_rl),
            .tick(tick)
        );

        // Transmit engine, also the sync shift engine in either direction
        wire tx_idle = (tx_state == DASC_TX_IDLE);
        wire tx_run = (tx_state == DASC_TX_RUN);
        wire tx_par = (^reg_wdata[7:0]) ^ par_odd;
        // Without a ninth bit this slot carries the first stop bit
        wire tx_ninth = !nine ? 1'b1 : (par_on ? tx_par : reg_wdata[8]);
        wire [3:0] tx_bits = 4'hA + {3'b000, nine} + {3'b000, two_stop};
        wire start_tx = wr_tx && tx_idle && en;
        wire start_srx = wr_ctrl && tx_idle && reg_wdata[`DASC_CTRL_EN] && reg_wdata[`DASC_CTRL_SYNC]
            && reg_wdata[`DASC_CTRL_REN];
        // Sync transfers restart the divider so the first clock half is whole; async keeps it free running
        assign baud_run = en && !(start_srx || (start_tx && sync_m));
        wire ph_end = tick && (tx_ph == (sync_m ? 4'h1 : `DASC_PH_LAST));
        wire tx_last = tx_run && ph_end && (tx_cnt == 4'h1);
        wire tx_ev = tx_last && !sx_rx;
        wire s_done = tx_last && sx_rx;
        wire srx_sample = tx_run && sx_rx && sync_m && tick && (tx_ph == 4'h0);
        wire next_txd = !tx_run ? 1'b1 : (sync_m ? tx_ph[0] : txsh[0]);

        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                tx_state <= DASC_TX_IDLE;
                txsh <= 12'hFFF;
                tx_cnt <= 4'h0;
                tx_ph <= 4'h0;
                sx_rx <= 1'b0;
            end else begin
                case (tx_state)
                    DASC_TX_IDLE: begin
                        tx_ph <= 4'h0;
                        if (start_tx) begin
                            txsh <= sync_m ? {4'hF, reg_wdata[7:0]} : {2'b11, tx_ninth, reg_wdata[7:0], 1'b0};
                            tx_cnt <= sync_m ? 4'h8 : tx_bits;
                            sx_rx <= 1'b0;
                            tx_state <= DASC_TX_RUN;
                        end else if (start_srx) begin
                            txsh <= 12'hFFF;
                            tx_cnt <= 4'h8;
                            sx_rx <= 1'b1;
                            tx_state <= DASC_TX_RUN;
                        end
                    end
                    DASC_TX_RUN: begin
                        if (tick) begin
                            tx_ph <= ph_end ? 4'h0 : tx_ph + 4'h1;
                        end
                        if (ph_end) begin
                            txsh <= {1'b1, txsh[11:1]};
                            tx_cnt <= tx_cnt - 4'h1;
                            if (tx_cnt == 4'h1) begin
                                tx_state <= DASC_TX_IDLE;
                            end
                        end
                    end
                    default: begin
                        tx_state <= DASC_TX_IDLE;
                    end
                endcase
            end
        end

        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                txd_q <= 1'b1;
                srxsh <= 8'h00;
            end else begin
                txd_q <= next_txd;
                if (srx_sample) begin
                    srxsh <= {pin_lvl, srxsh[7:1]};
                end
            end
        end

        assign txd[c] = txd_q;
        assign rxd_o[c] = txsh[0];
        assign rxd_oe[c] = tx_run && sync_m && !sx_rx;

        // Loopback feeds the own transmit line to the async receiver; sync receive still samples the external pin
        wire rx_line = loop ? txd_q : pin_lvl;

        // Pin input: three flops, a change counts once the last two agree
        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                pin_s1 <= 1'b1;
                pin_s2 <= 1'b1;
                pin_s3 <= 1'b1;
                pin_lvl <= 1'b1;
                line_q <= 1'b1;
            end else begin
                pin_s1 <= rxd_i[c];
                pin_s2 <= pin_s1;
                pin_s3 <= pin_s2;
                if (pin_s2 == pin_s3) begin
                    pin_lvl <= pin_s2;
                end
                line_q <= rx_line;
            end
        end

        // Asynchronous receiver, runs beside the transmitter
        wire rx_go = (rx_state == DASC_RX_IDLE) && en && !sync_m && ctrl[`DASC_CTRL_REN]
            && line_q && !rx_line;
        wire a_done = (rx_state == DASC_RX_DATA) && tick && (rx_ph == `DASC_PH_LAST) && (rx_cnt == 4'h1);
        wire [9:0] fin = {rx_line, rxsh[9:1]};
        wire [8:0] fin_data = nine ? fin[8:0] : {1'b0, fin[8:1]};
        wire accept = !(wake && !fin_data[8]);
        wire rx_ev_a = a_done && accept;
        wire pe_ev = rx_ev_a && par_on && ((^fin_data) ^ par_odd);
        wire fe_ev = rx_ev_a && ctrl[`DASC_CTRL_FE_EN] && !rx_line;
        wire rx_load = rx_ev_a || s_done;
        wire oe_ev = rx_load && rx_full && !rd_rx && ctrl[`DASC_CTRL_OE_EN];

        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                rx_state <= DASC_RX_IDLE;
                rxsh <= 10'h3FF;
                rx_cnt <= 4'h0;
                rx_ph <= 4'h0;
            end else begin
                case (rx_state)
                    DASC_RX_IDLE: begin
                        rx_ph <= 4'h0;
                        if (rx_go) begin
                            rx_state <= DASC_RX_START;
                        end
                    end
                    DASC_RX_START: begin
                        if (tick) begin
                            rx_ph <= rx_ph + 4'h1;
                            if (rx_ph == `DASC_PH_MID) begin
                                // A glitch shorter than half a bit is not a start bit
                                rx_state <= rx_line ? DASC_RX_IDLE : DASC_RX_DATA;
                                rx_ph <= 4'h0;
                                rx_cnt <= 4'h9 + {3'b000, nine};
                            end
                        end
                    end
                    DASC_RX_DATA: begin
                        if (tick) begin
                            rx_ph <= rx_ph + 4'h1;
                            if (rx_ph == `DASC_PH_LAST) begin
                                rxsh <= fin;
                                rx_cnt <= rx_cnt - 4'h1;
                                if (rx_cnt == 4'h1) begin
                                    rx_state <= DASC_RX_IDLE;
                                end
                            end
                        end
                    end
                    default: begin
                        rx_state <= DASC_RX_IDLE;
                    end
                endcase
            end
        end

        // Registers; a new character wins over a read in the same cycle
        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                ctrl <= `DASC_CTRL_RESET;
                baud_rl <= `DASC_BAUD_RESET;
                mask <= `DASC_MASK_RESET;
                rxbuf <= 9'h000;
                rx_full <= 1'b0;
                stat <= 6'h00;
            end else begin
                if (wr_ctrl) begin
                    ctrl <= reg_wdata;
                end else if (s_done) begin
                    ctrl <= ctrl & ~`DASC_CTRL_REN_MASK;
                end
                if (wr_baud) begin
                    baud_rl <= reg_wdata;
                end
                if (wr_mask) begin
                    mask <= reg_wdata[2:0];
                end
                if (rx_load) begin
                    rxbuf <= s_done ? {1'b0, srxsh} : fin_data;
                end
                rx_full <= rx_load || (rx_full && !rd_rx);
                stat <= (stat & ~(wr_stat ? reg_wdata[5:0] : 6'h00))
                    | {oe_ev, fe_ev, pe_ev, pe_ev || fe_ev || oe_ev, rx_load, tx_ev};
            end
        end

        assign irq_tx[c] = stat[`DASC_ST_TX] && mask[0];
        assign irq_rx[c] = stat[`DASC_ST_RX] && mask[1];
        assign irq_err[c] = stat[`DASC_ST_ERR] && mask[2];

        assign ch_rdata[c] = (idx == `DASC_REG_CTRL) ? ctrl
            : (idx == `DASC_REG_BAUD) ? baud_rl
            : (idx == `DASC_REG_RXBUF) ? {7'h00, rxbuf}
            : (idx == `DASC_REG_STAT) ? {8'h00, rx_full, !tx_idle, stat}
            : (idx == `DASC_REG_MASK) ? {13'h0000, mask}
            : 16'h0000;
    end
endmodule
`default_nettype wire

// File: testbench/dasc_props.sv
// Port-level checks of the dual serial channel
`timescale 1ns/100ps
`default_nettype none
`include "dasc_defs.svh"
module dasc_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Serial pins
    input wire logic [1:0] txd,
    input wire logic [1:0] rxd_i,
    input wire logic [1:0] rxd_o,
    input wire logic [1:0] rxd_oe,
    // Interrupts
    input wire logic [1:0] irq_tx,
    input wire logic [1:0] irq_rx,
    input wire logic [1:0] irq_err,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic prev;
        logic [7:0] run;
        logic [3:0] nfall;
        // Run starts saturated so the first edge after reset is not judged
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                prev <= 1'b1;
                run <= 8'hFF;
                nfall <= 4'h0;
            end else begin
                prev <= txd[c];
                run <= (txd[c] != prev) ? 8'h00 : ((run == 8'hFF) ? run : run + 8'h01);
                nfall <= !rxd_oe[c] ? 4'h0 : nfall + {3'h0, prev & !txd[c]};
            end
        end
        chk_bit_floor: assert property ((txd[c] != prev) |-> run >= 8'h0F)
            else $error("txd level shorter than the shortest bit half");
        chk_sync_eight: assert property ($fell(rxd_oe[c]) |-> nfall == 4'h8)
            else $error("sync transfer without eight shift clocks");
        chk_mask_gate: assert property (reg_wr && reg_addr == {1'(c), `DASC_REG_MASK} && reg_wdata[2:0] == 3'h0
            |=> {irq_tx[c], irq_rx[c], irq_err[c]} == 3'h0)
            else $error("request stays up with mask cleared");
        chk_w1c_clear: assert property (reg_wr && reg_addr == {1'(c), `DASC_REG_STAT} && reg_wdata[2:0] == 3'h7
            |=> {irq_tx[c], irq_rx[c], irq_err[c]} == 3'h0)
            else $error("request stays up after status clear");
    end
    chk_irq_or: assert property (irq == (|{irq_tx, irq_rx, irq_err}))
        else $error("summary request differs from the six requests");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the read answer");
    chk_unmapped_zero: assert property (reg_rd && (reg_addr[2:0] > 3'h5 || reg_addr[2:0] == 3'h2)
        |=> reg_rdata == 16'h0000)
        else $error("unmapped or write-only place reads non-zero");
    chk_stat_upper: assert property (reg_rd && reg_addr[2:0] == `DASC_REG_STAT |=> reg_rdata[15:8] == 8'h00)
        else $error("status upper byte non-zero");
    cov_sync: cover property ($rose(rxd_oe[1]));
    cov_err: cover property ($rose(irq_err[1]));
    cov_tx: cover property ($rose(irq_tx[0]));
endmodule
bind dasc_top dasc_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rxd_i(rxd_i), .rxd_o(rxd_o),
    .rxd_oe(rxd_oe), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err), .irq(irq));
`default_nettype wire

// File: testbench/dasc_peer.sv
// Far-end serial device driving the receive line of each channel
`timescale 1ns/100ps
`default_nettype none
module dasc_peer #(
    parameter int BIT_CYCLES = 160
) (
    // Clock
    input wire logic clk,
    // Lines towards the channels, idle at mark
    output var logic [1:0] line
);
    initial line = 2'b11;
    // Caller builds the frame LSB first: start, data, ninth, stops
    task automatic send(input int ch, input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line[ch] <= f[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
        line[ch] <= 1'b1;
    endtask
    task automatic hold(input int ch, input logic v);
        line[ch] <= v;
    endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the dual serial channel
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk, rst_n, reg_wr, reg_rd, irq;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [1:0] txd, rxd_o, rxd_oe, irq_tx, irq_rx, irq_err;
    logic [11:0] bits;
    int fails, n_tests;
    wire logic [1:0] line;
    // Line level from the device driver and the far end
    wire logic [1:0] rxd = (rxd_oe & rxd_o) | (~rxd_oe & line);
    dasc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rxd_i(rxd), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
        .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err), .irq(irq));
    // Bit time of 160 clocks is the fastest async rate
    dasc_peer #(.BIT_CYCLES(160)) peer (.clk(ref_clk), .line(line));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic results;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    // Work happens 1 ns after each edge so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        chk(reg_rdata, exp);
        tick(1);
    endtask
    // Kind 0 waits on txd, kind 1 on the transmit request
    task automatic wait_on(input int kind, input int ch, input logic val);
        for (int i = 0; i < 5000; i++) begin
            if ((kind == 1 ? irq_tx[ch] : txd[ch]) === val) return;
            tick(1);
        end
        fails++;
        results;
    endtask
    task automatic t_reset;
        for (int a = 0; a < 16; a++) rc(4'(a), 16'h0000);
        wr(4'h6, 16'hFFFF);
        rc(4'h6, 16'h0000);
        wr(4'h1, 16'h0009);
        rc(4'h1, 16'h0009);
        wr(4'hD, 16'h0000);
    endtask
    task automatic t_async_tx;
        wr(4'h5, 16'h0001);
        wr(4'h0, 16'h0001);
        wr(4'h2, 16'h00A5);
        bits = 12'h000;
        wait_on(0, 0, 1'b0);
        tick(80);
        for (int i = 0; i < 10; i++) begin
            bits[i] = txd[0];
            tick(160);
        end
        chk({4'h0, bits}, 16'h034A);
        wait_on(1, 0, 1'b1);
        rc(4'h4, 16'h0001);
        wr(4'h5, 16'h0000);
        chkb(irq_tx[0], 1'b0);
        wr(4'h5, 16'h0001);
        chkb(irq, 1'b1);
        wr(4'h4, 16'h003F);
        chkb(irq_tx[0], 1'b0);
    endtask
    task automatic rx_case(input logic [11:0] f, input logic [15:0] st, input logic [15:0] bv, input logic take);
        wr(4'hC, 16'h003F);
        peer.send(1, f, 11);
        rc(4'hC, st);
        if (take) rc(4'hB, bv);
        chkb(irq_err[1], st[2]);
        chkb(irq_rx[1], st[1]);
    endtask
    task automatic t_rx;
        wr(4'hD, 16'h0007);
        wr(4'h8, 16'h0711);
        rx_case(12'h54A, 16'h0082, 16'h00A5, 1'b0);
        rx_case(12'h54A, 16'h00A6, 16'h00A5, 1'b1);
        rx_case(12'h74A, 16'h008E, 16'h01A5, 1'b1);
        rx_case(12'h14A, 16'h0096, 16'h00A5, 1'b1);
    endtask
    task automatic t_wake;
        wr(4'h8, 16'h0441);
        rx_case(12'h466, 16'h0000, 16'h0000, 1'b0);
        rx_case(12'h666, 16'h0082, 16'h0133, 1'b1);
    endtask
    // External line held at space: any leak would corrupt the frame
    task automatic t_loop;
        peer.hold(0, 1'b0);
        wr(4'h0, 16'h0481);
        wr(4'h2, 16'h005A);
        wait_on(1, 0, 1'b1);
        rc(4'h4, 16'h0083);
        rc(4'h3, 16'h005A);
        peer.hold(0, 1'b1);
    endtask
    task automatic t_sync;
        wr(4'h8, 16'h0003);
        wr(4'hD, 16'h0001);
        wr(4'hC, 16'h003F);
        wr(4'hA, 16'h003C);
        bits = 12'h000;
        for (int i = 0; i < 8; i++) begin
            wait_on(0, 1, 1'b0);
            wait_on(0, 1, 1'b1);
            bits[i] = rxd[1];
        end
        chk({4'h0, bits}, 16'h003C);
        wait_on(1, 1, 1'b1);
        chkb(rxd_oe[1], 1'b0);
        // Sync receive of an idle-high line must shift in exactly eight ones
        wr(4'h8, 16'h0403);
        tick(400);
        rc(4'hB, 16'h00FF);
        rc(4'h8, 16'h0003);
    endtask
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fails = 0;
        n_tests = 0;
        rst_n = 1'b0;
        tick(4);
        rst_n <= 1'b1;
        tick(3);
        t_reset;
        t_async_tx;
        t_rx;
        t_wake;
        t_loop;
        t_sync;
        results;
    end
endmodule
`default_nettype wire
